// ### hdl/thi_pkg.sv
// Package of constants and types for the two-hand initiation interlock.
// What this block does
// - Start the weld from the palm switches only if both close within 0.5 s of each other.
// - Both palm switches must stay closed until the squeeze interval has finished.
// - Switches still held after the schedule ends never start a repeat initiation.
// - In chained operation, hold both switches through the last valve-adding squeeze.
// - In two-hand mode the stage inputs work normally and share the first stage schedule.
// - Raise a fault output when the second switch misses the 0.5 s window.
// - Raise a separate output when a palm-paired weld sequence has reached its end; stage starts give none.
// - Palm switches pair only while the two-hand configuration bit is on.
package thi_pkg;
   // Pairing window in milliseconds, and the clock rate in kHz.
   localparam int unsigned WINDOW_MS   = 500;
   localparam int unsigned CLK_KHZ     = 125000;
   // Window length in clock cycles; milliseconds times kHz gives whole cycles.
   localparam int unsigned WINDOW_CYC  = WINDOW_MS * CLK_KHZ;
   localparam int unsigned SCHED_W     = 4;
   localparam logic [1:0]  SYNC_RST    = 2'h0;
   typedef enum logic [2:0] {
      THI_IDLE, THI_ONE, THI_SQZ, THI_RUN, THI_LOCK
   } thi_state_t;
endpackage

// ### hdl/thi_sync_if.sv
// Interface carrying raw pin levels into the synchroniser and clean levels back.
`timescale 1ns/10ps
interface thi_sync_if #(parameter int unsigned N = 4);
   logic [N-1:0] raw;
   logic [N-1:0] clean;
   modport src (output raw, input clean);
   modport snk (input raw, output clean);
endinterface

// ### hdl/thi_sync.sv
// Two-flip-flop synchroniser for the operator switch pins.
`timescale 1ns/10ps
module thi_sync
   import thi_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic nrst_i,
   thi_sync_if.snk   sig
);
   logic [sig.N-1:0] meta_ff;
   logic [sig.N-1:0] sync_ff;

   // The first stage feeds only the second one, to contain metastability.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= sig.raw;
         sync_ff <= meta_ff;
      end
   end

   assign sig.clean = sync_ff;
endmodule

// ### hdl/thi_top.sv
// Two-hand initiation interlock for the weld sequence controller.
`timescale 1ns/10ps
module thi_top
   import thi_pkg::*;
#(
   parameter int unsigned WIN_CYCLES = WINDOW_CYC
)(
   input  wire logic               core_clk_i,
   input  wire logic               nrst_i,
   input  wire logic               palm_switch_a_input_i,
   input  wire logic               palm_switch_b_input_i,
   input  wire logic               first_stage_initiate_input_i,
   input  wire logic               second_stage_initiate_input_i,
   input  wire logic               two_hand_enable_i,
   input  wire logic [SCHED_W-1:0] use_schedule_i,
   input  wire logic               squeeze_done_i,
   input  wire logic               schedule_done_i,
   output logic                    weld_start_o,
   output logic                    stage2_start_o,
   output logic [SCHED_W-1:0]      schedule_sel_o,
   output logic                    weld_abort_o,
   output logic                    pairing_fault_indicator_output_o,
   output logic                    sequence_end_indicator_output_o
);
   // This interlock runs on one clock with no redundant channel, so it suits
   // a supervised station and is no substitute for a certified safety relay.
   // The window counter needs at least two counts to tell a lone hand from
   // a pair; smaller values cannot be served.
   if (WIN_CYCLES < 2) begin : g_win_chk
      $error("WIN_CYCLES must be at least 2");
   end

   //////////////////////////////////////////////////////////////////////////
   // Synchronise pins: palm a, palm b, first stage, second stage.
   thi_sync_if #(.N(4)) pins ();
   assign pins.raw = {second_stage_initiate_input_i, first_stage_initiate_input_i,
                      palm_switch_b_input_i, palm_switch_a_input_i};
   thi_sync u_sync (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .sig        (pins)
   );

   wire logic pa      = pins.clean[0];
   wire logic pb      = pins.clean[1];
   wire logic fs1     = pins.clean[2];
   wire logic fs2     = pins.clean[3];
   wire logic both    = pa & pb;
   wire logic anyp    = pa | pb;
   wire logic sqz_in  = squeeze_done_i;
   wire logic end_in  = schedule_done_i;

   //////////////////////////////////////////////////////////////////////////
   // State and window counter.
   thi_state_t state_ff, nxt_state;
   logic [31:0] win_ff, nxt_win;
   logic        fs1_ff, fs2_ff;
   logic        weld_start_ff, nxt_weld_start;
   logic        abort_ff, nxt_abort;
   logic        fault_ff, nxt_fault;
   logic        end_ff, nxt_end;
   logic        st2_ff;
   logic [SCHED_W-1:0] sel_ff;

   //////////////////////////////////////////////////////////////////////////
   // Named decode of the pairing conditions, kept out of the state machine.
   // The window spans WIN_CYCLES cycles of the one-hand state.
   wire logic win_out  = (win_ff >= WIN_CYCLES - 1);
   // Stage inputs act on their rising edge, so a held switch fires only once.
   wire logic fs1_rise = fs1 & ~fs1_ff;
   wire logic fs2_rise = fs2 & ~fs2_ff;
   // Palms pair only while the two-hand bit is on; otherwise they are ignored.
   wire logic pair_ok  = two_hand_enable_i & both;
   wire logic lone_ok  = two_hand_enable_i & anyp & ~both;
   // A dropped mode bit or a lifted lone hand ends the window without fault.
   wire logic one_quit = ~two_hand_enable_i | ~anyp;
   // Lock holds until both hands are off, so a held pair never re-arms.
   // A bounce of one hand alone therefore cannot sneak a second start in.
   wire logic all_open = ~anyp;

   // Pairing sequence; palm start, abort and end pulses and the fault level are decided here.
   always_comb begin
      nxt_state      = state_ff;
      nxt_win        = '0;
      nxt_weld_start = 1'b0;
      nxt_abort      = 1'b0;
      nxt_fault      = fault_ff;
      nxt_end        = 1'b0;
      case (state_ff)
         THI_IDLE: begin
            // Either hand pressed in two-hand mode clears the fault shown for the last attempt.
            if (pair_ok) begin
               nxt_state      = THI_SQZ;
               nxt_weld_start = 1'b1;
               nxt_fault      = 1'b0;
            end else if (lone_ok) begin
               nxt_state = THI_ONE;
               nxt_fault = 1'b0;
            end
         end
         THI_ONE: begin
            nxt_win = win_ff + 32'h1;
            if (one_quit) begin
               nxt_state = THI_IDLE;
            end else if (both) begin
               nxt_state      = THI_SQZ;
               nxt_weld_start = 1'b1;
            end else if (win_out) begin
               nxt_state = THI_LOCK;
               nxt_fault = 1'b1;
            end
         end
         THI_SQZ: begin
            // Chained schedules keep reporting squeeze until the last valve adds.
            if (!both) begin
               nxt_state = THI_LOCK;
               nxt_abort = 1'b1;
            end else if (sqz_in) begin
               nxt_state = THI_RUN;
            end
         end
         THI_RUN: begin
            if (end_in) begin
               nxt_state = THI_LOCK;
               nxt_end   = 1'b1;
            end
         end
         THI_LOCK: begin
            if (all_open) begin
               nxt_state = THI_IDLE;
            end
         end
         default: nxt_state = THI_IDLE;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // Registers; every output of the block comes straight from one of these.
   // Each group has its own short process so that the reset values are easy
   // to hold against the promise that all outputs stay low in reset.

   // State and window count; reset lands in idle with no window running.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= THI_IDLE;
         win_ff   <= '0;
      end else begin
         state_ff <= nxt_state;
         win_ff   <= nxt_win;
      end
   end

   // Stage edge history; the reset value is the open level of the switches,
   // so releasing reset with a stage switch open never fakes an edge.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fs1_ff <= 1'b0;
         fs2_ff <= 1'b0;
      end else begin
         fs1_ff <= fs1;
         fs2_ff <= fs2;
      end
   end

   // Start pulse from a palm pairing or from a first stage edge.
   // Stage inputs keep working in two-hand mode, so both sources merge here.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         weld_start_ff <= 1'b0;
      end else begin
         weld_start_ff <= nxt_weld_start | fs1_rise;
      end
   end

   // Second stage pulse, one cycle per closing of the second stage switch.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st2_ff <= 1'b0;
      end else begin
         st2_ff <= fs2_rise;
      end
   end

   // Abort pulse; the timing engine must drop the schedule when it sees it.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         abort_ff <= 1'b0;
      end else begin
         abort_ff <= nxt_abort;
      end
   end

   // Fault level; it stands until the next press in two-hand mode so an operator can read it.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fault_ff <= 1'b0;
      end else begin
         fault_ff <= nxt_fault;
      end
   end

   // End-of-sequence pulse, raised only from the running state.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         end_ff <= 1'b0;
      end else begin
         end_ff <= nxt_end;
      end
   end

   // Schedule number, registered so the output never glitches with the input.
   // Palm starts and stage starts all run this one selected schedule.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sel_ff <= '0;
      end else begin
         sel_ff <= use_schedule_i;
      end
   end

   assign weld_start_o                     = weld_start_ff;
   assign stage2_start_o                   = st2_ff;
   assign schedule_sel_o                   = sel_ff;
   assign weld_abort_o                     = abort_ff;
   assign pairing_fault_indicator_output_o = fault_ff;
   assign sequence_end_indicator_output_o  = end_ff;
endmodule

// ### bench/thi_monitor.sv
// Port checker for the two-hand initiation interlock.
`timescale 1ns/10ps
module thi_monitor
   import thi_pkg::*;
(
   input wire logic               core_clk_i,
   input wire logic               nrst_i,
   input wire logic               palm_switch_a_input_i,
   input wire logic               palm_switch_b_input_i,
   input wire logic               first_stage_initiate_input_i,
   input wire logic               second_stage_initiate_input_i,
   input wire logic               two_hand_enable_i,
   input wire logic [SCHED_W-1:0] use_schedule_i,
   input wire logic               schedule_done_i,
   input wire logic               weld_start_o,
   input wire logic               stage2_start_o,
   input wire logic [SCHED_W-1:0] schedule_sel_o,
   input wire logic               weld_abort_o,
   input wire logic               pairing_fault_indicator_output_o,
   input wire logic               sequence_end_indicator_output_o
);
   // Pin paths see two sync stages and one output register, hence depth 3.
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   start_one_a: assert property (weld_start_o |=> !weld_start_o) else $error("start width");
   // The mode bit is decided one cycle before the start pulse shows.
   start_cause_a: assert property (weld_start_o |->
      $past(first_stage_initiate_input_i, 3) || ($past(two_hand_enable_i) &&
      $past(palm_switch_a_input_i, 3) && $past(palm_switch_b_input_i, 3)))
      else $error("start without cause");
   stage_two_a: assert property (stage2_start_o |->
      $past(second_stage_initiate_input_i, 3)) else $error("stage two without cause");
   abort_cause_a: assert property (weld_abort_o |->
      !($past(palm_switch_a_input_i, 3) && $past(palm_switch_b_input_i, 3)))
      else $error("abort while held");
   fault_cause_a: assert property ($rose(pairing_fault_indicator_output_o) |->
      $past(palm_switch_a_input_i, 3) != $past(palm_switch_b_input_i, 3))
      else $error("fault without lone press");
   end_cause_a: assert property (sequence_end_indicator_output_o |->
      $past(schedule_done_i)) else $error("end without done");
   end_one_a: assert property (sequence_end_indicator_output_o |=>
      !sequence_end_indicator_output_o) else $error("end width");
   sel_copy_a: assert property ($past(nrst_i) |->
      schedule_sel_o == $past(use_schedule_i)) else $error("schedule copy");
endmodule
bind thi_top thi_monitor mon_u (.*);

// ### bench/thi_operator.sv
// Operator model: two normally open palm buttons.
`timescale 1ns/10ps
module thi_operator (
   input  wire logic clk_i,
   output logic      sw_a_o,
   output logic      sw_b_o
);
   initial begin
      sw_a_o = 1'h0;
      sw_b_o = 1'h0;
   end
   // Close one hand, the other after gap cycles; a long gap is a slow hand.
   task automatic press(input int gap);
      @(posedge clk_i) sw_a_o <= 1'h1;
      repeat (gap) @(posedge clk_i);
      sw_b_o <= 1'h1;
   endtask
   // Open both hands together.
   task automatic release_all();
      @(posedge clk_i) sw_a_o <= 1'h0;
      sw_b_o <= 1'h0;
   endtask
endmodule

// ### bench/test_thi_top.sv
// Self-checking bench for the two-hand initiation interlock.
`timescale 1ns/10ps
module test_thi_top;
   import thi_pkg::*;
   logic       clk = 1'h0, rst_n = 1'h0, fs1 = 1'h0, fs2 = 1'h0, en = 1'h1;
   logic       sqd = 1'h0, scd = 1'h0, sa, sb, ws, s2, ab, flt, se;
   logic [3:0] use_s = 4'h0, sel;
   int         n[4] = '{0, 0, 0, 0};
   int         failures = 0, comparisons = 0;
   always #4 clk = ~clk;
   // Pulse tallies: start, stage two, abort, end.
   always @(posedge clk) begin
      n[0] <= n[0] + ws;
      n[1] <= n[1] + s2;
      n[2] <= n[2] + ab;
      n[3] <= n[3] + se;
   end
   thi_operator op_u (.clk_i(clk), .sw_a_o(sa), .sw_b_o(sb));
   thi_top #(.WIN_CYCLES(20)) dut_u (.core_clk_i(clk), .nrst_i(rst_n),
      .palm_switch_a_input_i(sa), .palm_switch_b_input_i(sb),
      .first_stage_initiate_input_i(fs1), .second_stage_initiate_input_i(fs2),
      .two_hand_enable_i(en), .use_schedule_i(use_s), .squeeze_done_i(sqd),
      .schedule_done_i(scd), .weld_start_o(ws), .stage2_start_o(s2), .schedule_sel_o(sel),
      .weld_abort_o(ab), .pairing_fault_indicator_output_o(flt),
      .sequence_end_indicator_output_o(se));
   task automatic stop_test();
      $display("Checks %0d mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [3:0] got, logic [3:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Bounded wait for a tally; running out ends the run.
   task automatic expect_n(int k, int want, string nm);
      for (int i = 0; i < 40 && n[k] != want; i++) @(posedge clk);
      chk(nm, 4'(n[k]), 4'(want));
      if (n[k] != want) stop_test();
   endtask
   // Paired press, full schedule, hands kept down past the end.
   task automatic s_pair();
      op_u.press(3);
      expect_n(0, 1, "start");
      @(posedge clk) sqd <= 1'h1;
      @(posedge clk) sqd <= 1'h0;
      scd <= 1'h1;
      @(posedge clk) scd <= 1'h0;
      expect_n(3, 1, "end");
      repeat (30) @(posedge clk);
      chk("repeat", 4'(n[0]), 4'h1);
      op_u.release_all();
   endtask
   // Second hand too late, then a retry released inside squeeze.
   task automatic s_miss();
      op_u.press(25);
      repeat (5) @(posedge clk);
      chk("fault", 4'(flt), 4'h1);
      chk("locked", 4'(n[0]), 4'h1);
      op_u.release_all();
      op_u.press(2);
      expect_n(0, 2, "retry");
      chk("fault clear", 4'(flt), 4'h0);
      op_u.release_all();
      expect_n(2, 1, "abort");
   endtask
   // Mode off: palms ignored, stage inputs still start with the set schedule.
   task automatic s_off();
      @(posedge clk) en <= 1'h0;
      op_u.press(1);
      repeat (10) @(posedge clk);
      chk("disabled", 4'(n[0]), 4'h2);
      op_u.release_all();
      use_s <= 4'h9;
      fs1 <= 1'h1;
      expect_n(0, 3, "stage one");
      chk("schedule", sel, 4'h9);
      fs2 <= 1'h1;
      expect_n(1, 1, "stage two");
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      s_pair();
      s_miss();
      s_off();
      stop_test();
   end
endmodule
